// ==== icdt_pkg.sv ====
// Shared constants and types for the capture block with dedicated counter
package icdt_pkg;
    // Register addresses on the plain register port
    localparam logic [1:0] ADDR_CTRL1 = 2'h0;
    localparam logic [1:0] ADDR_CTRL2 = 2'h1;
    localparam logic [1:0] ADDR_BUF = 2'h2;
    // First control register fields
    localparam int B_SIDL = 13;
    localparam int TSEL_LO = 10;
    localparam int ICI_LO = 5;
    localparam int B_OV = 4;
    localparam int B_BNE = 3;
    localparam int MODE_LO = 0;
    // Second control register fields
    localparam int B_CASCADE_ENABLE_BIT = 8;
    localparam int B_TRIG = 7;
    localparam int B_TSTAT = 6;
    localparam int SYNC_LO = 0;
    localparam logic [4:0] SYNC_RESET = 5'h0D;
    localparam logic [4:0] SYNC_NONE = 5'h00;
    // Clock select codes
    localparam logic [2:0] TSEL_SYS = 3'h7;
    localparam logic [2:0] TSEL_T1 = 3'h4;
    localparam logic [2:0] TSEL_T5 = 3'h3;
    localparam logic [2:0] TSEL_T4 = 3'h2;
    localparam logic [2:0] TSEL_T2 = 3'h1;
    localparam logic [2:0] TSEL_T3 = 3'h0;
    // Counter and buffer sizes
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam int FIFO_DEPTH = 4;
    localparam logic [3:0] PRE4_LAST = 4'h3;
    localparam logic [3:0] PRE16_LAST = 4'hF;
    typedef enum logic [2:0] {
        MODE_OFF = 3'h0,
        MODE_BOTH = 3'h1,
        MODE_FALL = 3'h2,
        MODE_RISE = 3'h3,
        MODE_PRE4 = 3'h4,
        MODE_PRE16 = 3'h5,
        MODE_DIS = 3'h6,
        MODE_WAKE = 3'h7
    } icdt_mode_t;
endpackage : icdt_pkg

// ==== icdt_fifo_if.sv ====
// Interface between the capture core and its value buffer
`timescale 1ns/1ps
interface icdt_fifo_if;
    logic push;
    logic pop;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic empty;
    logic full;
    logic [2:0] level;
    modport fifo (input push, pop, wdata, output rdata, empty, full, level);
    modport user (output push, pop, wdata, input rdata, empty, full, level);
endinterface : icdt_fifo_if

// ==== icdt_fifo.sv ====
// Four-entry buffer of captured counter values
`timescale 1ns/1ps
module icdt_fifo import icdt_pkg::*; (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Buffer port
    icdt_fifo_if.fifo f
);
    logic [15:0] mem [FIFO_DEPTH];
    logic [1:0] wp;
    logic [1:0] rp;
    logic [2:0] level;
    logic do_push;
    logic do_pop;

    // A push into a full buffer is dropped; the core flags the loss
    assign do_push = f.push && !f.full;
    assign do_pop = f.pop && !f.empty;
    assign f.rdata = mem[rp];
    assign f.empty = (level == 3'h0);
    assign f.full = (level == 3'(FIFO_DEPTH));
    assign f.level = level;

    always_ff @(posedge clk_i) begin
        if (do_push) begin
            mem[wp] <= f.wdata;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wp <= 2'h0;
            rp <= 2'h0;
            level <= 3'h0;
        end else begin
            if (do_push) begin
                wp <= wp + 2'h1;
            end
            if (do_pop) begin
                rp <= rp + 2'h1;
            end
            if (do_push && !do_pop) begin
                level <= level + 3'h1;
            end else if (do_pop && !do_push) begin
                level <= level - 3'h1;
            end
        end
    end
endmodule : icdt_fifo

// ==== icdt_edge.sv ====
// Edge qualifier and edge prescaler for the capture input
`timescale 1ns/1ps
module icdt_edge import icdt_pkg::*; (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Synchronised pin and control
    input wire logic pin_i,
    input wire logic en_i,
    input wire icdt_mode_t mode_i,
    // Events
    output logic cap_o,
    output logic rise_o
);
    logic prev;
    logic fall;
    logic [3:0] pre;
    logic [3:0] pre_last;

    assign rise_o = pin_i && !prev;
    assign fall = !pin_i && prev;
    assign pre_last = (mode_i == MODE_PRE16) ? PRE16_LAST : PRE4_LAST;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev <= 1'b0;
        end else begin
            prev <= pin_i;
        end
    end

    // Prescaler restarts whenever capturing is not allowed
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pre <= 4'h0;
        end else if (!en_i) begin
            pre <= 4'h0;
        end else if (rise_o && (mode_i == MODE_PRE4 ||
                                mode_i == MODE_PRE16)) begin
            pre <= (pre == pre_last) ? 4'h0 : pre + 4'h1;
        end
    end

    always_comb begin
        cap_o = 1'b0;
        unique case (mode_i)
            MODE_BOTH: cap_o = rise_o || fall;
            MODE_FALL: cap_o = fall;
            MODE_RISE: cap_o = rise_o;
            MODE_PRE4, MODE_PRE16: cap_o = rise_o && pre == pre_last;
            MODE_OFF, MODE_DIS, MODE_WAKE: cap_o = 1'b0;
        endcase
        if (!en_i) begin
            cap_o = 1'b0;
        end
    end
endmodule : icdt_edge

// ==== icdt_capture.sv ====
// Input capture module with its own 16-bit counter and value buffer
`timescale 1ns/1ps
//
// Behaviour
// - Free-running counter wraps FFFFh to 0000h
// - Each capture stores current counter value
// - Sync mode: counter resets on sync event
// - Trigger mode: counter stopped until sync event
// - Source zero, trigger clear gives free-running
// - Source zero, trigger set: software trigger
// - Cascade: odd wraps increment even counter
// - Cascade needs enable bit in both modules
// - Cascade: same selections, even runs synchronously
// - Sync cascade held in reset until enabled
// - Not-empty bit shows buffer holds data
// - Overflow bit shows a capture was lost
// - Stop-in-idle bit halts module when idle
// - Clock select picks counter time base
// - Interrupt after one to four captures; both-edges mode interrupts on every capture, a cascaded even half never
// - Mode field selects edges or off
// - Trigger status set by hardware, clear holds zero
// - Source select maps to sync sources
// - Trigger mode captures nothing before trigger
// - Buffer holds four capture values
module icdt_capture import icdt_pkg::*; #(
    parameter bit IS_EVEN = 1'b0
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Register port
    input wire logic [1:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    // Capture pin, asynchronous
    input wire logic capture_input_pin_i,
    // Time bases: timer1..timer5 count pulses in bits 0..4
    input wire logic [4:0] timer_tick_i,
    // Sync and trigger sources, indexed by source select code
    input wire logic [31:0] sync_evt_i,
    input wire logic [31:0] sync_en_i,
    // Processor power state
    input wire logic cpu_idle_i,
    input wire logic cpu_sleep_i,
    // Cascade partner
    input wire logic partner_cascade_i,
    input wire logic partner_wrap_i,
    input wire logic partner_cap_i,
    output logic cascade_o,
    output logic wrap_o,
    output logic cap_o,
    // Events
    output logic capture_irq_o,
    output logic wake_irq_o
);
    icdt_fifo_if f ();

    logic pin_m;
    logic pin_s;
    logic stop_in_idle_bit;
    logic [2:0] clock_select_field;
    logic [1:0] interrupt_rate_field;
    icdt_mode_t mode_field;
    logic overflow_status_bit;
    logic cascade_enable_bit;
    logic trigger_select_bit;
    logic trigger_status_bit;
    logic [4:0] source_select;
    logic [15:0] capture_counter;
    logic [1:0] irq_cnt;
    logic casc_act;
    logic even_act;
    logic trig_mode;
    logic sync_mode;
    logic src_evt;
    logic src_on;
    logic held;
    logic halted;
    logic step;
    logic run;
    logic cap_en;
    logic edge_cap;
    logic edge_rise;
    logic cap_evt;
    logic wr_c1;
    logic wr_c2;
    logic rd_buf;

    function automatic logic pick_src(input logic [31:0] v,
                                      input logic [4:0] sel);
        // Code zero means no source; reserved codes have no wire
        return (sel == SYNC_NONE) ? 1'b0 : v[sel];
    endfunction : pick_src

    function automatic logic pick_tick(input logic [4:0] t,
                                       input logic [2:0] sel);
        logic r;
        r = 1'b0;
        unique case (sel)
            TSEL_SYS: r = 1'b1;
            TSEL_T1: r = t[0];
            TSEL_T2: r = t[1];
            TSEL_T3: r = t[2];
            TSEL_T4: r = t[3];
            TSEL_T5: r = t[4];
            default: r = 1'b0;
        endcase
        return r;
    endfunction : pick_tick

    // Pin synchroniser
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_m <= 1'b0;
            pin_s <= 1'b0;
        end else begin
            pin_m <= capture_input_pin_i;
            pin_s <= pin_m;
        end
    end

    assign wr_c1 = wr_i && addr_i == ADDR_CTRL1;
    assign wr_c2 = wr_i && addr_i == ADDR_CTRL2;
    assign rd_buf = rd_i && addr_i == ADDR_BUF;

    // Mode decode
    assign casc_act = cascade_enable_bit && partner_cascade_i;
    assign even_act = IS_EVEN && casc_act;
    // The even half ignores its own trigger bit and follows the odd one
    assign trig_mode = trigger_select_bit && !even_act;
    assign sync_mode = !trig_mode && source_select != SYNC_NONE;
    assign src_evt = pick_src(sync_evt_i, source_select);
    assign src_on = pick_src(sync_en_i, source_select);
    assign held = mode_field == MODE_OFF ||
                  (trig_mode && !trigger_status_bit) ||
                  (sync_mode && !src_on);
    assign halted = stop_in_idle_bit && cpu_idle_i;
    assign step = even_act ? partner_wrap_i :
                  pick_tick(timer_tick_i, clock_select_field);
    assign run = !held && !halted;
    assign cap_en = run && mode_field != MODE_WAKE;

    icdt_edge u_edge (
        .clk_i (clk_i),
        .rst_n_i (rst_n_i),
        .pin_i (pin_s),
        .en_i (cap_en && !even_act),
        .mode_i (mode_field),
        .cap_o (edge_cap),
        .rise_o (edge_rise)
    );

    // The even half captures on the odd half's event
    assign cap_evt = even_act ? (partner_cap_i && cap_en) : edge_cap;

    icdt_fifo u_fifo (
        .clk_i (clk_i),
        .rst_n_i (rst_n_i),
        .f (f.fifo)
    );

    assign f.push = cap_evt;
    assign f.wdata = capture_counter;
    assign f.pop = rd_buf;

    // Control register one
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stop_in_idle_bit <= 1'b0;
            clock_select_field <= TSEL_T3;
            interrupt_rate_field <= 2'h0;
            mode_field <= MODE_OFF;
        end else if (wr_c1) begin
            stop_in_idle_bit <= wdata_i[B_SIDL];
            clock_select_field <= wdata_i[TSEL_LO +: 3];
            interrupt_rate_field <= wdata_i[ICI_LO +: 2];
            mode_field <= icdt_mode_t'(wdata_i[MODE_LO +: 3]);
        end
    end

    // Control register two; a hardware trigger wins over a software clear
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cascade_enable_bit <= 1'b0;
            trigger_select_bit <= 1'b0;
            trigger_status_bit <= 1'b0;
            source_select <= SYNC_RESET;
        end else begin
            if (wr_c2) begin
                cascade_enable_bit <= wdata_i[B_CASCADE_ENABLE_BIT];
                trigger_select_bit <= wdata_i[B_TRIG];
                trigger_status_bit <= wdata_i[B_TSTAT];
                source_select <= wdata_i[SYNC_LO +: 5];
            end
            if (trig_mode && src_evt) begin
                trigger_status_bit <= 1'b1;
            end
        end
    end

    // Capture counter
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            capture_counter <= CNT_ZERO;
        end else if (held) begin
            capture_counter <= CNT_ZERO;
        end else if (halted) begin
            capture_counter <= capture_counter;
        end else if (sync_mode && src_evt) begin
            capture_counter <= CNT_ZERO;
        end else if (step) begin
            capture_counter <= capture_counter + 16'h0001;
        end
    end

    // Overflow flag: a new loss wins over a clear by read or turn-off
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            overflow_status_bit <= 1'b0;
        end else if (cap_evt && f.full) begin
            overflow_status_bit <= 1'b1;
        end else if ((rd_buf && !f.empty) || mode_field == MODE_OFF) begin
            overflow_status_bit <= 1'b0;
        end
    end

    // Capture-rate interrupt; lost captures still count as events
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_cnt <= 2'h0;
            capture_irq_o <= 1'b0;
        end else begin
            capture_irq_o <= 1'b0;
            if (mode_field == MODE_OFF) begin
                irq_cnt <= 2'h0;
            end else if (cap_evt && mode_field == MODE_BOTH) begin
                capture_irq_o <= !even_act;
            end else if (cap_evt && irq_cnt >= interrupt_rate_field) begin
                irq_cnt <= 2'h0;
                capture_irq_o <= !even_act;
            end else if (cap_evt) begin
                irq_cnt <= irq_cnt + 2'h1;
            end
        end
    end

    // Partner links and wake event
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wrap_o <= 1'b0;
            cap_o <= 1'b0;
            cascade_o <= 1'b0;
            wake_irq_o <= 1'b0;
        end else begin
            // One-cycle lag on both links keeps the halves consistent
            wrap_o <= run && step && capture_counter == CNT_MAX;
            cap_o <= cap_evt;
            cascade_o <= cascade_enable_bit;
            wake_irq_o <= mode_field == MODE_WAKE && edge_rise &&
                          (cpu_idle_i || cpu_sleep_i);
        end
    end

    // Read data, valid in the cycle after the strobe
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= 16'h0000;
        end else if (rd_i) begin
            unique case (addr_i)
                ADDR_CTRL1: rdata_o <= {2'h0, stop_in_idle_bit,
                    clock_select_field, 3'h0, interrupt_rate_field,
                    overflow_status_bit, !f.empty,
                    mode_field};
                ADDR_CTRL2: rdata_o <= {7'h00, cascade_enable_bit,
                    trigger_select_bit, trigger_status_bit, 1'b0,
                    source_select};
                ADDR_BUF: rdata_o <= f.empty ? 16'h0000 : f.rdata;
                default: rdata_o <= 16'h0000;
            endcase
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    property p_wrap;
        run && step && !(sync_mode && src_evt) &&
        capture_counter == CNT_MAX |=> capture_counter == CNT_ZERO;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("counter did not wrap to zero");

    property p_store;
        cap_evt && !f.full |=> !f.empty && f.level == $past(f.level) +
            3'h1 - 3'($past(rd_buf && !f.empty));
    endproperty
    a_store: assert property (p_store)
        else $error("capture not stored");

    property p_sync_clr;
        sync_mode && src_evt && run |=> capture_counter == CNT_ZERO;
    endproperty
    a_sync_clr: assert property (p_sync_clr)
        else $error("sync event did not clear counter");

    property p_trig_hold;
        trig_mode && !trigger_status_bit && !src_evt && !wr_c2
        |=> capture_counter == CNT_ZERO && !cap_evt;
    endproperty
    a_trig_hold: assert property (p_trig_hold)
        else $error("counter ran before trigger");

    property p_trig_set;
        trig_mode && src_evt |=> trigger_status_bit;
    endproperty
    a_trig_set: assert property (p_trig_set)
        else $error("trigger status not set");

    property p_idle;
        !held && halted ##1 !held |-> $stable(capture_counter);
    endproperty
    a_idle: assert property (p_idle)
        else $error("counter moved while halted in idle");

    property p_ovf;
        cap_evt && f.full |=> overflow_status_bit &&
            f.level == 3'(FIFO_DEPTH) - 3'($past(rd_buf));
    endproperty
    a_ovf: assert property (p_ovf)
        else $error("overflow not flagged");

    property p_bne;
        rd_i && addr_i == ADDR_CTRL1 |=> rdata_o[B_BNE] == !$past(f.empty);
    endproperty
    a_bne: assert property (p_bne)
        else $error("not-empty bit wrong");

    property p_pop;
        rd_buf && !f.empty && !cap_evt |=> f.level == $past(f.level) - 3'h1;
    endproperty
    a_pop: assert property (p_pop)
        else $error("buffer read did not pop");

    property p_rate;
        mode_field == MODE_RISE && interrupt_rate_field == 2'h0 &&
        cap_evt && !even_act |=> capture_irq_o;
    endproperty
    a_rate: assert property (p_rate)
        else $error("no interrupt on every capture");

    c_fill: cover property (f.full ##1 overflow_status_bit);
    c_wrap: cover property (wrap_o);
    c_trig: cover property (!trigger_status_bit ##1 trigger_status_bit);
    c_irq4: cover property (interrupt_rate_field == 2'h3 && capture_irq_o);
endmodule : icdt_capture

// ==== icdt_pulse_src.sv ====
// Behavioural source of pulse trains on the capture pin
`timescale 1ns/1ps
module icdt_pulse_src (
    // Clock
    input wire logic clk_i,
    // Request: pulse count and half period in clock cycles
    input wire logic go_i,
    input wire logic [5:0] count_i,
    input wire logic [3:0] half_i,
    // Pin and status
    output logic pin_o,
    output logic busy_o
);
    // Pin idles low so that no stray edge appears between trains
    initial begin
        pin_o = 1'b0;
        busy_o = 1'b0;
        forever begin
            @(posedge clk_i);
            if (go_i) begin
                busy_o <= 1'b1;
                repeat (count_i) begin
                    pin_o <= 1'b1;
                    repeat (half_i) @(posedge clk_i);
                    pin_o <= 1'b0;
                    repeat (half_i) @(posedge clk_i);
                end
                busy_o <= 1'b0;
            end
        end
    end
endmodule : icdt_pulse_src

// ==== icdt_capture_tb.sv ====
// Self-checking bench for the capture block
`timescale 1ns/1ps
module icdt_capture_tb import icdt_pkg::*;;
    logic clk_i, rst_n_i, wr, rd, pin, idle, go, busy, casc, wrap, irq, wake;
    logic sleep, sel_e, casc_e, capo;
    logic [1:0] addr;
    logic [15:0] wdata, rdata, rdata_e, v, v0, v1;
    logic [4:0] tick;
    logic [31:0] sevt, sen;
    logic [5:0] npul;
    logic [3:0] half;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;
    int n_irq = 0;
    int n_wake = 0;
    int n_wrap = 0;
    int i0, w0, k;
    int exp_mode[8] = '{0, 32, 16, 16, 4, 1, 0, 0};
    logic [2:0] tsel[6] = '{3'h4, 3'h1, 3'h0, 3'h2, 3'h3, 3'h7};

    icdt_capture #(.IS_EVEN(1'b0)) u_dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr && !sel_e), .rd_i(rd && !sel_e), .rdata_o(rdata),
        .capture_input_pin_i(pin),
        .timer_tick_i(tick), .sync_evt_i(sevt), .sync_en_i(sen),
        .cpu_idle_i(idle), .cpu_sleep_i(sleep), .partner_cascade_i(casc_e),
        .partner_wrap_i(1'b0), .partner_cap_i(1'b0), .cascade_o(casc),
        .wrap_o(wrap), .cap_o(capo), .capture_irq_o(irq), .wake_irq_o(wake)
    );

    // Even half of a cascaded pair; it captures on the odd half's event
    icdt_capture #(.IS_EVEN(1'b1)) u_even (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr && sel_e), .rd_i(rd && sel_e), .rdata_o(rdata_e),
        .capture_input_pin_i(pin), .timer_tick_i(tick), .sync_evt_i(sevt),
        .sync_en_i(sen), .cpu_idle_i(idle), .cpu_sleep_i(sleep),
        .partner_cascade_i(casc), .partner_wrap_i(wrap),
        .partner_cap_i(capo), .cascade_o(casc_e), .wrap_o(), .cap_o(),
        .capture_irq_o(), .wake_irq_o()
    );

    icdt_pulse_src u_src (
        .clk_i(clk_i), .go_i(go), .count_i(npul), .half_i(half),
        .pin_o(pin), .busy_o(busy)
    );

    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // Event counters; tests take differences, so they never reset
    always @(posedge clk_i) begin
        cycles++;
        if (irq === 1'b1) n_irq++;
        if (wake === 1'b1) n_wake++;
        if (wrap === 1'b1) n_wrap++;
        if (cycles >= 90000) begin
            num_errors++;
            $display("CHECK FAILED at %0t: timeout", $time);
            summarize();
        end
    end

    task automatic summarize();
        if (num_errors == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got,
                     exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [1:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [1:0] a, output logic [15:0] d);
        @(posedge clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        #1;
        d = sel_e ? rdata_e : rdata;
    endtask : rd_reg

    // Turn off, drain, then select sources before the mode
    task automatic cfg(input logic [15:0] c2, input logic [15:0] c1);
        wr_reg(ADDR_CTRL1, 16'h0000);
        repeat (5) rd_reg(ADDR_BUF, v);
        wr_reg(ADDR_CTRL2, c2);
        wr_reg(ADDR_CTRL1, c1);
    endtask : cfg

    task automatic pulses(input int n, input int h);
        int j;
        @(posedge clk_i);
        npul <= n[5:0];
        half <= h[3:0];
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        j = 0;
        #1;
        while (busy && j < 3000) begin
            @(posedge clk_i);
            #1;
            j++;
        end
        // Let the synchroniser and edge pipeline settle
        repeat (8) @(posedge clk_i);
    endtask : pulses

    task automatic irq_run(input int n, input int h, input int exp_irq);
        i0 = n_irq;
        pulses(n, h);
        chk(16'(n_irq - i0), exp_irq[15:0]);
    endtask : irq_run

    task automatic gap(input int exp);
        rd_reg(ADDR_BUF, v0);
        rd_reg(ADDR_BUF, v1);
        chk(v1 - v0, exp[15:0]);
    endtask : gap

    initial begin
        rst_n_i = 1'b0;
        addr = 2'h0;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
        idle = 1'b0;
        sleep = 1'b0;
        sel_e = 1'b0;
        go = 1'b0;
        // Timer three ticks every cycle unless a test picks another line
        tick = 5'h04;
        sevt = 32'h0000_0000;
        sen = 32'h0000_0000;
        npul = 6'h00;
        half = 4'h0;
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd_reg(ADDR_CTRL1, v);
        chk(v, 16'h0000);
        rd_reg(ADDR_CTRL2, v);
        chk(v, 16'h000D);
        rd_reg(ADDR_BUF, v);
        chk(v, 16'h0000);
        wr_reg(2'h3, 16'hFFFF);
        rd_reg(2'h3, v);
        chk(v, 16'h0000);
        wr_reg(ADDR_CTRL1, 16'hFFFF);
        rd_reg(ADDR_CTRL1, v);
        chk(v, 16'h3C67);
        wr_reg(ADDR_CTRL2, 16'hFFFF);
        rd_reg(ADDR_CTRL2, v);
        chk(v, 16'h01DF);
        chk({15'h0000, casc}, 16'h0001);
        wr_reg(ADDR_CTRL2, 16'h000D);
        wr_reg(ADDR_CTRL1, 16'h0003);
        irq_run(2, 4, 0);
        @(posedge clk_i);
        sen <= 32'h0000_2000;
        irq_run(2, 4, 2);
        gap(8);
        repeat (100) @(posedge clk_i);
        sevt <= 32'h0000_2000;
        @(posedge clk_i);
        sevt <= 32'h0000_0000;
        pulses(1, 4);
        rd_reg(ADDR_BUF, v);
        chk({15'h0000, v < 16'h0010}, 16'h0001);
        sen <= 32'h0000_0000;
        cfg(16'h0000, 16'h0003);
        pulses(5, 3);
        rd_reg(ADDR_CTRL1, v);
        chk(v, 16'h001B);
        rd_reg(ADDR_BUF, v0);
        for (k = 0; k < 3; k++) begin
            rd_reg(ADDR_BUF, v1);
            chk(v1 - v0, 16'h0006);
            v0 = v1;
        end
        rd_reg(ADDR_CTRL1, v);
        chk(v, 16'h0003);
        rd_reg(ADDR_BUF, v);
        chk(v, 16'h0000);
        for (k = 0; k < 8; k++) begin
            cfg(16'h0000, 16'(k));
            idle <= (k == 7);
            w0 = n_wake;
            irq_run(16, 2, exp_mode[k]);
            chk(16'(n_wake - w0), (k == 7) ? 16'h0010 : 16'h0000);
        end
        idle <= 1'b0;
        sleep <= 1'b1;
        w0 = n_wake;
        pulses(2, 2);
        chk(16'(n_wake - w0), 16'h0002);
        sleep <= 1'b0;
        cfg(16'h0000, 16'h0061);
        irq_run(4, 2, 8);
        for (k = 0; k < 4; k++) begin
            cfg(16'h0000, 16'((k << 5) | 3));
            irq_run(12, 2, 12 / (k + 1));
        end
        cfg(16'h0000, 16'h2003);
        idle <= 1'b1;
        irq_run(3, 2, 0);
        wr_reg(ADDR_CTRL1, 16'h0003);
        irq_run(3, 2, 3);
        idle <= 1'b0;
        cfg(16'h0080, 16'h0003);
        irq_run(2, 2, 0);
        wr_reg(ADDR_CTRL2, 16'h00C0);
        irq_run(2, 2, 2);
        cfg(16'h008B, 16'h0003);
        irq_run(2, 2, 0);
        @(posedge clk_i);
        sevt <= 32'h0000_0800;
        @(posedge clk_i);
        sevt <= 32'h0000_0000;
        rd_reg(ADDR_CTRL2, v);
        chk(v, 16'h00CB);
        irq_run(2, 5, 2);
        gap(10);
        // Only the selected tick line is active, so a bad map counts 0;
        // the last pass has no tick at all and runs on the clock itself
        for (k = 0; k < 6; k++) begin
            cfg(16'h0000, {3'h0, tsel[k], 10'h003});
            tick <= 5'(1 << k);
            irq_run(2, 4, 2);
            gap(8);
        end
        tick <= 5'h04;
        cfg(16'h0000, 16'h0003);
        chk({15'h0000, casc}, 16'h0000);
        // Even half first and held off, so it starts from zero in step
        sel_e <= 1'b1;
        cfg(16'h0100, 16'h0000);
        sel_e <= 1'b0;
        cfg(16'h0100, 16'h0003);
        sel_e <= 1'b1;
        wr_reg(ADDR_CTRL1, 16'h0003);
        w0 = n_wrap;
        repeat (65544) @(posedge clk_i);
        chk(16'(n_wrap - w0), 16'h0001);
        sel_e <= 1'b0;
        pulses(1, 4);
        rd_reg(ADDR_CTRL1, v);
        chk(v, 16'h000B);
        rd_reg(ADDR_BUF, v0);
        sel_e <= 1'b1;
        rd_reg(ADDR_BUF, v1);
        chk({15'h0000, v0 < 16'h0040}, 16'h0001);
        chk(v1, 16'h0001);
        summarize();
    end
endmodule : icdt_capture_tb
